//--- design/prbs_lane_checker.sv
module prbs_lane_checker
	import prbs_test_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic enable,
	input wire logic restart,
	input wire logic sym_valid,
	input wire logic [SYM_W-1:0] sym,
	output logic synced,
	output logic failed,
	output logic error
);
	typedef enum logic [2:0] {
		CK_HUNT = 3'b001,
		CK_WAIT = 3'b010,
		CK_CHECK = 3'b100
	} ck_state_e;

	ck_state_e state;
	logic [SYNC_CNT_W-1:0] stp_cnt;
	logic [3:0] idx;
	logic [LFSR_W-1:0] lfsr;

	// compare against a private copy of the generator
	prbs_step_s step;
	logic is_stp;
	logic take;
	logic mismatch;
	logic last_sym;
	assign step = prbs_next(lfsr);
	assign is_stp = (sym == STP_SYMBOL);
	assign take = sym_valid && ((state == CK_CHECK) || (state == CK_WAIT && !is_stp));
	assign mismatch = take && (sym != step.symbol);
	assign last_sym = (idx == 4'(SEQ_SYMBOLS - 1));

	// hunt discards stp symbols, wait skips the stp gap between sequences
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= CK_HUNT;
			stp_cnt <= '0;
			idx <= '0;
			lfsr <= LFSR_SEED;
			synced <= 1'b0;
			failed <= 1'b0;
			error <= 1'b0;
		end else if (ce) begin
			error <= 1'b0;
			if (restart || !enable) begin
				state <= CK_HUNT;
				stp_cnt <= '0;
				idx <= '0;
				lfsr <= LFSR_SEED;
				synced <= 1'b0;
				failed <= 1'b0;
			end else if (sym_valid) begin
				case (state)
					CK_HUNT: begin
						stp_cnt <= is_stp ? stp_cnt + 1'b1 : '0;
						if (is_stp && stp_cnt == SYNC_CNT_W'(SYNC_STP_COUNT - 1)) begin
							state <= CK_WAIT;
							synced <= 1'b1;
						end
					end
					CK_WAIT, CK_CHECK: begin
						if (take) begin
							error <= mismatch;
							failed <= failed | mismatch;
							lfsr <= last_sym ? LFSR_SEED : step.state;
							idx <= last_sym ? '0 : idx + 1'b1;
							state <= last_sym ? CK_WAIT : CK_CHECK;
						end
					end
					default: state <= CK_HUNT;
				endcase
			end
		end
	end

	a_sync_on_stp: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(synced) |-> $past(sym_valid && is_stp && stp_cnt == SYNC_CNT_W'(SYNC_STP_COUNT - 1)))
		else $error("sync declared without the full stp run");
	a_fail_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(failed && ce && !restart && enable) |=> failed)
		else $error("fail bit dropped without a restart");
endmodule

//--- design/prbs_test_pkg.sv
package prbs_test_pkg;
	// lane and port geometry
	localparam int NUM_LANES = 24;
	localparam int LANES_PER_PORT = 8;
	localparam int NUM_PORTS = 3;
	localparam int NUM_COUNTERS = 6;
	localparam int SYM_W = 10;
	localparam int LFSR_W = 7;
	localparam int CNT_W = 8;
	// mode codes on the mode-select pins
	localparam logic [3:0] MODE_LOOP10 = 4'h8;
	localparam logic [3:0] MODE_INT_PRBS = 4'hA;
	localparam logic [3:0] MODE_EXT_PRBS = 4'hB;
	// stream shape
	localparam logic [6:0] LFSR_SEED = 7'h7F;
	localparam int TAP_HI = 6;
	localparam int TAP_LO = 5;
	localparam logic [9:0] STP_SYMBOL = 10'h17C;
	localparam int STP_COUNT = 1024;
	localparam int STP_CNT_W = $clog2(STP_COUNT);
	localparam int SEQ_BITS = 127;
	localparam int SEQ_SYMBOLS = (SEQ_BITS + SYM_W - 1) / SYM_W;
	localparam int SYNC_STP_COUNT = 64;
	localparam int SYNC_CNT_W = $clog2(SYNC_STP_COUNT);
	// synchronised pin vector layout
	localparam int PIN_MODE_LSB = 0;
	localparam int PIN_FRST = 4;
	localparam int PIN_INIT = 5;
	localparam int PIN_RXCLK = 6;
	localparam int PIN_W = 7;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_INVERT = 8'h04;
	localparam logic [7:0] OFF_SERDES = 8'h08;
	localparam logic [7:0] OFF_SYNC = 8'h0C;
	localparam logic [7:0] OFF_FAIL = 8'h10;
	localparam logic [7:0] OFF_CNT_CFG = 8'h14;
	localparam logic [7:0] OFF_COUNT_LO = 8'h18;
	localparam logic [7:0] OFF_COUNT_HI = 8'h1C;
	localparam logic [7:0] OFF_MODE = 8'h20;
	// field positions and reset values
	localparam int TRANSMIT_RESYNC_BIT_BIT = 24;
	localparam int RECEIVE_RESYNC_BIT_BIT = 25;
	localparam int LBDRV_BIT = 24;
	localparam int MODE_RUN_BIT = 4;
	localparam int MODE_NORMAL_BIT = 5;
	localparam logic [23:0] LANE_EN_RESET = 24'hFFFFFF;

	typedef struct packed {
		logic [LFSR_W-1:0] state;
		logic [SYM_W-1:0] symbol;
	} prbs_step_s;

	typedef struct packed {
		logic [1:0] port;
		logic [2:0] lane;
	} cnt_sel_s;

	// ten bit-clock steps of the lfsr, first bit lands in the symbol msb
	// the feedback bit is also the emitted bit, so the seed itself is never sent
	function automatic prbs_step_s prbs_next(input logic [LFSR_W-1:0] s);
		prbs_step_s r;
		logic fb;
		r.state = s;
		r.symbol = '0;
		fb = 1'b0;
		for (int i = 0; i < SYM_W; i++) begin
			fb = r.state[TAP_HI] ^ r.state[TAP_LO];
			r.symbol = {r.symbol[SYM_W-2:0], fb};
			r.state = {r.state[LFSR_W-2:0], fb};
		end
		return r;
	endfunction
endpackage

//--- design/serdes_prbs_test_modes.sv
// Summary of operation
// - mode code on mode-select pins during fundamental reset picks the test mode
// - test boot: wait reset clear, serdes init, sample straps, decode, slave, run
// - register slave keeps answering reads and writes throughout any test mode
// - per-lane invert bit inverts that lane's transmitted stream
// - lane loopback enables plus drive option loop external modes on-chip
// - code 0x8 loops each lane's received data back inside the serdes
// - ten-bit loopback: port enabled only while all its lane-enable bits are set
// - ten-bit loopback reports no failure and performs no synchronisation
// - code 0xA generates prbs, loops it internally and checks it
// - self-test lanes start active; software enables each lane by its bit
// - generator sends 1024 stp symbols then 127-bit sequence, repeating forever
// - seven-bit lfsr, polynomial x^7+x^6+1, seeded all ones
// - lfsr steps per bit clock into ten-bit register, one symbol per ten bits
// - generated symbols follow the reference table values
// - checker discards stp symbols and declares sync after 64 of them
// - first non-stp after sync is symbol one; mismatch sets lane fail bit
// - six counters select a lane by port and lane fields, count its errors
// - checking wraps to sequence start after last symbol, no resync
// - writing transmit or receive resync restarts generator or checker sync
// - code 0xB transmits on the lane and expects an external loop back
// - external self-test checker runs on recovered receive clock; here it runs on pclk, paced by rx_clk edges found through the pin synchroniser
//
// The address map and register access over APB were left to the implementer.
module serdes_prbs_test_modes
	import prbs_test_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fundamental_reset_n,
	input wire logic [3:0] device_mode_select_pins,
	input wire logic serdes_init_done,
	input wire logic rx_clk,
	input wire logic [NUM_LANES*SYM_W-1:0] rx_symbols,
	output logic serdes_init_req,
	output logic [NUM_LANES*SYM_W-1:0] tx_symbols,
	output logic tx_valid,
	output logic serdes_loopback_10b,
	output logic [NUM_LANES-1:0] serdes_internal_loopback,
	output logic [NUM_LANES-1:0] serdes_lane_active,
	output logic normal_mode,
	output logic test_running
);
	typedef enum logic [6:0] {
		B_WAIT_RST = 7'b0000001,
		B_SERDES = 7'b0000010,
		B_SAMPLE = 7'b0000100,
		B_DECODE = 7'b0001000,
		B_SLAVE = 7'b0010000,
		B_TEST = 7'b0100000,
		B_NORMAL = 7'b1000000
	} boot_state_e;

	typedef enum logic [2:0] {
		G_IDLE = 3'b001,
		G_STP = 3'b010,
		G_SEQ = 3'b100
	} gen_state_e;

	// three-stage pin synchronisers; a change is accepted when stages two and three agree
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic [PIN_W-1:0] pin_s3;
	logic [PIN_W-1:0] pin_f;
	logic [PIN_W-1:0] pin_agree;
	assign pin_raw = {rx_clk, serdes_init_done, fundamental_reset_n, device_mode_select_pins};
	assign pin_agree = ~(pin_s2 ^ pin_s3);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
			pin_s3 <= '0;
			pin_f <= '0;
		end else if (ce) begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f <= (pin_s3 & pin_agree) | (pin_f & ~pin_agree);
		end
	end

	logic frst_n_f;
	logic init_done_f;
	logic rx_clk_f;
	logic [3:0] mode_f;
	assign frst_n_f = pin_f[PIN_FRST];
	assign init_done_f = pin_f[PIN_INIT];
	assign rx_clk_f = pin_f[PIN_RXCLK];
	assign mode_f = pin_f[PIN_MODE_LSB +: 4];

	// boot sequencer for the test modes
	boot_state_e boot;
	logic [3:0] mode_code;
	logic slave_up;
	logic code_is_test;
	assign code_is_test = (mode_f == MODE_LOOP10) || (mode_f == MODE_INT_PRBS)
		|| (mode_f == MODE_EXT_PRBS);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot <= B_WAIT_RST;
			mode_code <= '0;
			slave_up <= 1'b0;
		end else if (ce) begin
			case (boot)
				B_WAIT_RST: if (frst_n_f) boot <= B_SERDES;
				B_SERDES: if (init_done_f) boot <= B_SAMPLE;
				B_SAMPLE: begin
					mode_code <= mode_f;
					boot <= B_DECODE;
				end
				B_DECODE: boot <= (mode_code == mode_f && code_is_test) ? B_SLAVE : B_NORMAL;
				B_SLAVE: begin
					slave_up <= 1'b1;
					boot <= B_TEST;
				end
				B_TEST, B_NORMAL: begin
					slave_up <= 1'b1;
					if (!frst_n_f) begin
						boot <= B_WAIT_RST;
						slave_up <= 1'b0;
					end
				end
				default: boot <= B_WAIT_RST;
			endcase
		end
	end

	logic test_start;
	logic is_loop10;
	logic is_int;
	logic is_ext;
	logic is_prbs;
	assign test_start = (boot == B_SLAVE) && ce;
	assign test_running = (boot == B_TEST);
	assign normal_mode = (boot == B_NORMAL);
	assign serdes_init_req = (boot == B_SERDES);
	assign is_loop10 = test_running && (mode_code == MODE_LOOP10);
	assign is_int = test_running && (mode_code == MODE_INT_PRBS);
	assign is_ext = test_running && (mode_code == MODE_EXT_PRBS);
	assign is_prbs = is_int || is_ext;

	// software registers
	logic [NUM_LANES-1:0] lane_en;
	logic [NUM_LANES-1:0] invert_stream_bit;
	logic [NUM_LANES-1:0] internal_loopback_lane_enables;
	logic loopback_drive_option;
	cnt_sel_s [NUM_COUNTERS-1:0] cnt_sel;
	logic tx_resync;
	logic rx_resync;
	logic [NUM_LANES-1:0] sync_achieved;
	logic [NUM_LANES-1:0] test_fail;
	logic [NUM_LANES-1:0] lane_err;
	logic [CNT_W-1:0] lane_error_count [NUM_COUNTERS];

	// apb decode; zero wait states, unmapped or pre-release access answers with pslverr
	logic acc;
	logic wr;
	logic hit_ctrl;
	logic hit_inv;
	logic hit_serdes;
	logic hit_sync;
	logic hit_fail;
	logic hit_cfg;
	logic hit_cnt_lo;
	logic hit_cnt_hi;
	logic hit_mode;
	logic hit_any;
	logic [31:0] rd_mux;
	assign acc = psel && penable;
	assign wr = acc && pwrite && slave_up && ce;
	assign hit_ctrl = (paddr == OFF_CTRL);
	assign hit_inv = (paddr == OFF_INVERT);
	assign hit_serdes = (paddr == OFF_SERDES);
	assign hit_sync = (paddr == OFF_SYNC);
	assign hit_fail = (paddr == OFF_FAIL);
	assign hit_cfg = (paddr == OFF_CNT_CFG);
	assign hit_cnt_lo = (paddr == OFF_COUNT_LO);
	assign hit_cnt_hi = (paddr == OFF_COUNT_HI);
	assign hit_mode = (paddr == OFF_MODE);
	assign hit_any = hit_ctrl | hit_inv | hit_serdes | hit_sync | hit_fail | hit_cfg
		| hit_cnt_lo | hit_cnt_hi | hit_mode;
	assign pready = 1'b1;
	assign pslverr = acc && !(hit_any && slave_up);
	assign rd_mux = hit_ctrl ? {8'h00, lane_en}
		: hit_inv ? {8'h00, invert_stream_bit}
		: hit_serdes ? {7'h00, loopback_drive_option, internal_loopback_lane_enables}
		: hit_sync ? {8'h00, sync_achieved}
		: hit_fail ? {8'h00, test_fail}
		: hit_cfg ? {2'h0, cnt_sel}
		: hit_cnt_lo ? {lane_error_count[3], lane_error_count[2], lane_error_count[1],
			lane_error_count[0]}
		: hit_cnt_hi ? {16'h0000, lane_error_count[5], lane_error_count[4]}
		: hit_mode ? {26'h0000000, normal_mode, test_running, mode_code}
		: 32'h00000000;

	// read data is captured in the setup phase so it comes from a flop in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (ce) begin
			if (psel && !penable) prdata <= slave_up ? rd_mux : 32'h00000000;
		end
	end

	// writable fields; resync bits are write-one pulses and read back as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lane_en <= LANE_EN_RESET;
			invert_stream_bit <= '0;
			internal_loopback_lane_enables <= '0;
			loopback_drive_option <= 1'b0;
			cnt_sel <= '0;
			tx_resync <= 1'b0;
			rx_resync <= 1'b0;
		end else if (ce) begin
			tx_resync <= wr && hit_ctrl && pwdata[TRANSMIT_RESYNC_BIT_BIT];
			rx_resync <= wr && hit_ctrl && pwdata[RECEIVE_RESYNC_BIT_BIT];
			if (wr && hit_ctrl) lane_en <= pwdata[NUM_LANES-1:0];
			if (wr && hit_inv) invert_stream_bit <= pwdata[NUM_LANES-1:0];
			if (wr && hit_serdes) begin
				internal_loopback_lane_enables <= pwdata[NUM_LANES-1:0];
				loopback_drive_option <= pwdata[LBDRV_BIT];
			end
			if (wr && hit_cfg) cnt_sel <= pwdata[NUM_COUNTERS*5-1:0];
		end
	end

	// generator: stp burst, then the lfsr sequence, repeated
	gen_state_e gstate;
	logic [STP_CNT_W-1:0] stp_cnt;
	logic [3:0] seq_idx;
	logic [LFSR_W-1:0] lfsr;
	prbs_step_s gstep;
	logic [SYM_W-1:0] cur_sym;
	logic gen_run;
	logic seq_last;
	assign gstep = prbs_next(lfsr);
	assign cur_sym = (gstate == G_SEQ) ? gstep.symbol : STP_SYMBOL;
	assign gen_run = is_prbs && (gstate != G_IDLE);
	assign seq_last = (seq_idx == 4'(SEQ_SYMBOLS - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gstate <= G_IDLE;
			stp_cnt <= '0;
			seq_idx <= '0;
			lfsr <= LFSR_SEED;
		end else if (ce) begin
			if (test_start || tx_resync) begin
				gstate <= G_STP;
				stp_cnt <= '0;
				seq_idx <= '0;
				lfsr <= LFSR_SEED;
			end else if (!test_running) begin
				gstate <= G_IDLE;
			end else begin
				case (gstate)
					G_STP: begin
						stp_cnt <= stp_cnt + 1'b1;
						if (stp_cnt == STP_CNT_W'(STP_COUNT - 1)) gstate <= G_SEQ;
					end
					G_SEQ: begin
						lfsr <= seq_last ? LFSR_SEED : gstep.state;
						seq_idx <= seq_last ? '0 : seq_idx + 1'b1;
						stp_cnt <= '0;
						if (seq_last) gstate <= G_STP;
					end
					default: gstate <= G_IDLE;
				endcase
			end
		end
	end

	// receive capture on the recovered clock edge, found through the pin synchroniser
	logic rx_prev;
	logic rx_edge;
	logic rx_sym_valid;
	logic [NUM_LANES*SYM_W-1:0] rx_hold;
	assign rx_edge = rx_clk_f && !rx_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_prev <= 1'b0;
			rx_sym_valid <= 1'b0;
			rx_hold <= '0;
			tx_valid <= 1'b0;
		end else if (ce) begin
			rx_prev <= rx_clk_f;
			rx_sym_valid <= rx_edge && is_ext;
			if (rx_edge) rx_hold <= rx_symbols;
			tx_valid <= gen_run;
		end
	end

	// per-port enable for ten-bit loopback
	logic [NUM_PORTS-1:0] port_en;
	logic chk_restart;
	assign chk_restart = test_start || rx_resync;
	assign serdes_loopback_10b = is_loop10;
	assign serdes_internal_loopback = is_int ? {NUM_LANES{1'b1}}
		: is_ext ? (internal_loopback_lane_enables & {NUM_LANES{loopback_drive_option}})
		: '0;

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		assign port_en[p] = &lane_en[p*LANES_PER_PORT +: LANES_PER_PORT];
	end

	// per-lane transmit, activity and checker
	for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
		logic act;
		logic from_tx;
		logic [SYM_W-1:0] chk_sym;
		logic chk_valid;
		assign act = is_loop10 ? port_en[l / LANES_PER_PORT] : (is_prbs && lane_en[l]);
		assign serdes_lane_active[l] = act;
		assign from_tx = serdes_internal_loopback[l];
		assign chk_sym = from_tx ? tx_symbols[l*SYM_W +: SYM_W] : rx_hold[l*SYM_W +: SYM_W];
		assign chk_valid = from_tx ? tx_valid : rx_sym_valid;

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tx_symbols[l*SYM_W +: SYM_W] <= '0;
			end else if (ce) begin
				tx_symbols[l*SYM_W +: SYM_W] <= (gen_run && act)
					? cur_sym ^ {SYM_W{invert_stream_bit[l]}} : '0;
			end
		end

		prbs_lane_checker u_chk (
			.pclk(pclk),
			.presetn(presetn),
			.ce(ce),
			.enable(is_prbs && lane_en[l]),
			.restart(chk_restart),
			.sym_valid(chk_valid),
			.sym(chk_sym),
			.synced(sync_achieved[l]),
			.failed(test_fail[l]),
			.error(lane_err[l])
		);
	end

	// error counters: lane picked by {port, lane}, saturating, cleared on test entry
	logic [31:0] lane_err_pad;
	assign lane_err_pad = 32'(lane_err);

	for (genvar c = 0; c < NUM_COUNTERS; c++) begin : g_cnt
		logic hit;
		assign hit = lane_err_pad[{cnt_sel[c].port, cnt_sel[c].lane}];
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				lane_error_count[c] <= '0;
			end else if (ce) begin
				if (test_start) lane_error_count[c] <= '0;
				else if (hit && lane_error_count[c] != '1) lane_error_count[c] <= lane_error_count[c] + 1'b1;
			end
		end
	end

	a_mode_capture: assert property (@(posedge pclk) disable iff (!presetn)
		(boot == B_SAMPLE && ce) |=> (mode_code == $past(mode_f)))
		else $error("mode code not taken from the pins");
	a_boot_order: assert property (@(posedge pclk) disable iff (!presetn)
		($rose(slave_up) && test_running) |-> ($past(boot) == B_SLAVE) && $past(mode_code == mode_f))
		else $error("slave released out of sequence");
	a_slave_alive: assert property (@(posedge pclk) disable iff (!presetn)
		(acc && test_running && hit_any) |-> (pready && !pslverr))
		else $error("register access refused during test");
	a_invert_lane: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && gen_run && serdes_lane_active[0]) |=>
		(tx_symbols[SYM_W-1:0] == ($past(cur_sym) ^ {SYM_W{$past(invert_stream_bit[0])}})))
		else $error("lane zero transmit symbol wrong");
	a_port_enable: assert property (@(posedge pclk) disable iff (!presetn)
		is_loop10 |-> (serdes_lane_active[LANES_PER_PORT-1:0] == {LANES_PER_PORT{port_en[0]}}))
		else $error("port activity does not follow its lane enables");
	a_loop10_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		(is_loop10 && $past(is_loop10)) |-> (test_fail == '0 && sync_achieved == '0))
		else $error("ten-bit loopback reported sync or fail");
	a_stp_to_seq: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && gstate == G_STP && stp_cnt == STP_CNT_W'(STP_COUNT - 1) && test_running
		&& !test_start && !tx_resync) |=> (gstate == G_SEQ && lfsr == LFSR_SEED))
		else $error("sequence did not follow the stp burst");
	a_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
		(ce && g_cnt[0].hit && !test_start && lane_error_count[0] != '1) |=>
		(lane_error_count[0] == $past(lane_error_count[0]) + 1'b1))
		else $error("error counter missed an error");
	a_cnt_saturate: assert property (@(posedge pclk) disable iff (!presetn)
		(lane_error_count[0] == '1 && !test_start) |=> (lane_error_count[0] == '1))
		else $error("error counter wrapped");
endmodule

//--- tb/prbs_stream_source.sv
module prbs_stream_source
	import prbs_test_pkg::*;
(
	input wire logic en,
	input wire logic bad,
	output logic rx_clk,
	output logic [NUM_LANES*SYM_W-1:0] rx_symbols
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [LFSR_W-1:0] r = 7'h7F;
	logic [SYM_W-1:0] s;
	int k = 0;
	// far-end pattern source: 70 start symbols then 13 sequence symbols, repeated
	initial begin
		rx_clk = 1'b0;
		rx_symbols = '0;
		forever begin
			if (!en) begin
				// clock parked low; data churns so a stale symbol never looks valid
				rx_symbols = ~rx_symbols;
				#80;
			end else begin
				s = STP_SYMBOL;
				if (k >= 70) begin
					for (int i = 0; i < SYM_W; i++) begin
						r = {r[5:0], r[6] ^ r[5]};
						s = {s[SYM_W-2:0], r[0]};
					end
					s = s ^ {9'h0, bad};
				end
				k = (k == 82) ? 0 : k + 1;
				if (k == 0) begin
					r = 7'h7F;
				end
				// same stream on every lane, fixed period tied to the reference
				rx_symbols = {NUM_LANES{s}};
				#80 rx_clk = 1'b1;
				#80 rx_clk = 1'b0;
			end
		end
	end
endmodule

//--- tb/serdes_prbs_test_modes_tb.sv
module serdes_prbs_test_modes_tb
	import prbs_test_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
	logic [7:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, frst_n = 0, init_done = 0, src_en = 0, src_bad = 0;
	logic [3:0] mode_pins = '0;
	logic rx_clk, init_req, tx_valid, lb10, normal, running;
	logic [NUM_LANES*SYM_W-1:0] rx_symbols, tx;
	logic [NUM_LANES-1:0] ilb, active;
	logic [9:0] s2, s3;
	int err_total = 0, checked = 0, seed = 19403, n, lane;

	always #2 pclk = ~pclk;

	serdes_prbs_test_modes u_serdes_prbs_test_modes (.pclk(pclk), .presetn(presetn), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .fundamental_reset_n(frst_n),
		.device_mode_select_pins(mode_pins), .serdes_init_done(init_done), .rx_clk(rx_clk),
		.rx_symbols(rx_symbols), .serdes_init_req(init_req), .tx_symbols(tx),
		.tx_valid(tx_valid), .serdes_loopback_10b(lb10), .serdes_internal_loopback(ilb),
		.serdes_lane_active(active), .normal_mode(normal), .test_running(running));

	prbs_stream_source u_prbs_stream_source (.en(src_en), .bad(src_bad), .rx_clk(rx_clk),
		.rx_symbols(rx_symbols));

	function automatic logic [9:0] sym_of(int l);
		return tx[l*SYM_W +: SYM_W];
	endfunction

	task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// pulse fundamental reset with a mode code; slave must stay closed until serdes is up
	task automatic boot(input logic [3:0] m);
		@(posedge pclk);
		frst_n <= 1'b0;
		mode_pins <= m;
		init_done <= 1'b0;
		repeat (4) @(posedge pclk);
		frst_n <= 1'b1;
		repeat (8) @(posedge pclk);
		apb(0, OFF_MODE, '0);
		chk("early_slverr", e, 1);
		chk("init_req", init_req, 1);
		init_done <= 1'b1;
	endtask

	// length of the start-symbol run on lane 0, then the 2nd and 3rd sequence symbols
	task automatic stp_len();
		@(negedge pclk);
		while (tx_valid !== 1'b1) @(negedge pclk);
		n = 0;
		while (sym_of(0) === STP_SYMBOL) begin
			n++;
			@(negedge pclk);
		end
		@(negedge pclk);
		s2 = sym_of(0);
		@(negedge pclk);
		s3 = sym_of(0);
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// hang guard, about four times the expected run
	initial begin
		#300000;
		err_total++;
		test_done();
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		boot(MODE_INT_PRBS);
		stp_len();
		chk("stp_run", n, 1024);
		chk("sym2", s2, 10'h0C2);
		chk("sym3", s3, 10'h23C);
		apb(0, OFF_MODE, '0);
		chk("mode", q, 32'h0000001A);
		apb(0, OFF_CTRL, '0);
		chk("lane_en", q, 32'h00FFFFFF);
		chk("int_loop", ilb, 24'hFFFFFF);
		repeat (20) @(posedge pclk);
		apb(1, OFF_CTRL, 32'h01FFFFFF);
		stp_len();
		// two old start symbols are still in flight when the restart lands
		chk("tx_resync", n, STP_COUNT + 2);
		repeat (1200) @(posedge pclk);
		apb(0, OFF_SYNC, '0);
		chk("sync", q, 32'h00FFFFFF);
		apb(0, OFF_FAIL, '0);
		chk("no_fail", q, 0);
		lane = $unsigned($random(seed)) % 8;
		apb(1, OFF_CNT_CFG, 32'h300 | lane);
		apb(1, OFF_INVERT, 32'h1 << lane);
		repeat (4) @(negedge pclk);
		chk("inverted", sym_of(lane) ^ sym_of(23), 10'h3FF);
		repeat (2000) @(posedge pclk);
		apb(0, OFF_FAIL, '0);
		chk("fail", q, 32'h1 << lane);
		apb(0, OFF_COUNT_LO, '0);
		chk("counters", q[15:0], 16'h00FF);
		apb(1, OFF_INVERT, '0);
		apb(1, OFF_CTRL, 32'h02FFFFFF);
		apb(0, OFF_FAIL, '0);
		chk("rx_resync_fail", q, 0);
		apb(0, OFF_SYNC, '0);
		chk("rx_resync_sync", q, 0);
		lane = 8 + $unsigned($random(seed)) % 16;
		apb(1, OFF_CTRL, 32'h00FFFFFF ^ (32'h1 << lane));
		repeat (3) @(negedge pclk);
		chk("lane_off", {active[lane], sym_of(lane)}, 0);
		apb(0, 8'h40, '0);
		chk("unmapped", e, 1);
		apb(1, OFF_CTRL, 32'h00FFFFFF);
		$display("internal self-test done");
		src_en <= 1'b1;
		boot(MODE_EXT_PRBS);
		repeat (20) @(posedge pclk);
		apb(1, OFF_SERDES, 32'h0100000F);
		@(negedge pclk);
		chk("ext_loop", ilb, 24'h00000F);
		apb(1, OFF_SERDES, '0);
		repeat (7000) @(posedge pclk);
		apb(0, OFF_SYNC, '0);
		chk("ext_sync", q, 32'h00FFFFFF);
		apb(0, OFF_FAIL, '0);
		chk("ext_clean", q, 0);
		src_bad <= 1'b1;
		repeat (4000) @(posedge pclk);
		apb(0, OFF_FAIL, '0);
		chk("ext_fail", q, 32'h00FFFFFF);
		$display("external self-test done");
		boot(MODE_LOOP10);
		repeat (20) @(posedge pclk);
		chk("loop10", lb10, 1);
		apb(1, OFF_CTRL, 32'h00FFFDFF);
		@(negedge pclk);
		chk("port_off", active, 24'hFF00FF);
		repeat (3000) @(posedge pclk);
		apb(0, OFF_SYNC, '0);
		chk("loop_sync", q, 0);
		apb(0, OFF_FAIL, '0);
		chk("loop_fail", q, 0);
		$display("loopback done");
		boot(4'h0);
		repeat (20) @(posedge pclk);
		chk("normal", {normal, running}, 2'b10);
		$display("normal boot done");
		test_done();
	end
endmodule
